// file: core/pll_coast_clamp_control.v
// pll line length, coast window, clamp timing and offset control behind an axi4-lite slave
//
// Contract
// RULE1: offset low registers carry offset bits 1:0 in bits 7:6; bits 5:0 unused.
// RULE2: loop off, offset high byte drives DAC upper bits; loop on, digital offset.
// RULE3: line length is 14 bits: high register bits 5:0, low register bits 7:0.
// RULE4: new line length applied only on low byte write; write high byte first.
// RULE5: 6-bit sampling phase, 5.625 degrees per step within the pixel.
// RULE6: pre-coast count sets lines of coasting before vertical sync starts.
// RULE7: post-coast count sets lines of coasting after vertical sync ends.
// RULE8: option bit 0 picks lock edge: 0 trailing, 1 leading horizontal sync edge.
// RULE9: option bit 1 gates the clock invert pin: 0 ignored, 1 effective.
// RULE10: option bit 2 picks coast source: 0 internal window, 1 external input.
// RULE11: option bit 3 sets external coast polarity: 0 active high, 1 active low.
// RULE12: option bit 4 selects pixel clock: 0 internal pll, 1 external pin.
// RULE13: 14-bit clamp start pixel counted from raw horizontal sync trailing edge.
// RULE14: clamp width only drives the AC-coupled restore clamp; no effect DC-coupled.
// RULE15: clamp width zero keeps the clamp DAC disconnected on every line.
// RULE16: loop on, offset word is signed: mid code zero, min most negative.
// RULE17: oversampling multiplies line length, clamp start and width by its ratio.
// RULE18: during the coast window the pll holds and ignores horizontal sync edges.
// RULE19: clamp stays on for width pixel clocks from the start pixel each line.
`include "pll_coast_clamp_regs.vh"
`timescale 1ns/1ns
`default_nettype none

module pll_coast_clamp_control #(
  parameter LINE_W = 17
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        hsync_in,
  input  wire        vsync_in,
  input  wire        coast_in,
  input  wire        clock_invert_pin,
  output reg  [9:0]  green_offset_dac,
  output reg  [9:0]  blue_offset_dac,
  output reg  [9:0]  green_digital_offset,
  output reg  [9:0]  blue_digital_offset,
  output reg  [LINE_W-1:0] pll_line_length,
  output reg         pll_line_load,
  output reg  [5:0]  pll_phase_step,
  output reg         pll_coast,
  output reg         pll_lock_pulse,
  output reg         pll_clock_invert,
  output reg         use_external_pixel_clock_pin,
  output reg         clamp_active
);

  // register storage
  reg [7:0] red_offset_low_q, green_offset_high_q, green_offset_low_q;
  reg [7:0] blue_offset_high_q, blue_offset_low_q;
  reg [7:0] line_length_high_q, line_length_low_q, sample_phase_q;
  reg [7:0] coast_before_vsync_q, coast_after_vsync_q, pll_options_q;
  reg [7:0] clamp_start_high_q, clamp_start_low_q, clamp_width_q;
  reg [7:0] front_end_config_q;
  reg       aw_hold_q, w_hold_q;
  reg [31:0] awaddr_q, wdata_q;
  reg [3:0]  wstrb_q;

  wire        do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
  wire [29:0] wr_idx   = awaddr_q[31:2];
  wire [7:0]  wbyte    = wdata_q[7:0];
  wire        wr_hit   = (wr_idx >= {22'h0, `IDX_RED_OFFSET_LOW}) &&
                         (wr_idx <= {22'h0, `IDX_FRONT_END_CONFIG});
  wire        wr_low   = wstrb_q[0] && wr_hit; // refused writes store nothing

  // write channels captured independently, either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      awaddr_q      <= 32'h0;
      wdata_q       <= 32'h0;
      wstrb_q       <= 4'h0;
    end
    else
    begin
      s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
      end
    end
  end

  // register writes; only byte lane 0 carries data, other lanes ignored
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      red_offset_low_q     <= `RST_OFFSET_LOW;
      green_offset_high_q  <= `RST_OFFSET_HIGH;
      green_offset_low_q   <= `RST_OFFSET_LOW;
      blue_offset_high_q   <= `RST_OFFSET_HIGH;
      blue_offset_low_q    <= `RST_OFFSET_LOW;
      line_length_high_q   <= `RST_LINE_LENGTH_HIGH;
      line_length_low_q    <= `RST_LINE_LENGTH_LOW;
      sample_phase_q       <= `RST_SAMPLE_PHASE;
      coast_before_vsync_q <= `RST_COAST_LINES;
      coast_after_vsync_q  <= `RST_COAST_LINES;
      pll_options_q        <= `RST_PLL_OPTIONS;
      clamp_start_high_q   <= `RST_CLAMP_START_HIGH;
      clamp_start_low_q    <= `RST_CLAMP_START_LOW;
      clamp_width_q        <= `RST_CLAMP_WIDTH;
      front_end_config_q   <= `RST_FRONT_END_CONFIG;
    end
    else if (do_write && wr_low)
    begin
      case (wr_idx[7:0])
        `IDX_RED_OFFSET_LOW:     red_offset_low_q     <= {wbyte[7:6], 6'h00}; // [RULE1]
        `IDX_GREEN_OFFSET_HIGH:  green_offset_high_q  <= wbyte;
        `IDX_GREEN_OFFSET_LOW:   green_offset_low_q   <= {wbyte[7:6], 6'h00}; // [RULE1]
        `IDX_BLUE_OFFSET_HIGH:   blue_offset_high_q   <= wbyte;
        `IDX_BLUE_OFFSET_LOW:    blue_offset_low_q    <= {wbyte[7:6], 6'h00}; // [RULE1]
        `IDX_LINE_LENGTH_HIGH:   line_length_high_q   <= {2'h0, wbyte[5:0]}; // [RULE3]
        `IDX_LINE_LENGTH_LOW:    line_length_low_q    <= wbyte;
        `IDX_SAMPLE_PHASE:       sample_phase_q       <= {2'h0, wbyte[5:0]}; // [RULE5]
        `IDX_COAST_BEFORE_VSYNC: coast_before_vsync_q <= wbyte;
        `IDX_COAST_AFTER_VSYNC:  coast_after_vsync_q  <= wbyte;
        `IDX_PLL_OPTIONS:        pll_options_q        <= {3'h0, wbyte[4:0]};
        `IDX_CLAMP_START_HIGH:   clamp_start_high_q   <= {2'h0, wbyte[5:0]}; // [RULE13]
        `IDX_CLAMP_START_LOW:    clamp_start_low_q    <= wbyte;
        `IDX_CLAMP_WIDTH:        clamp_width_q        <= wbyte;
        `IDX_FRONT_END_CONFIG:   front_end_config_q   <= {4'h0, wbyte[3:0]};
        default:                 pll_options_q        <= pll_options_q;
      endcase
    end
  end

  // a single outstanding read, answered two cycles after arvalid
  reg [7:0] rd_byte;
  reg       rd_hit;
  reg       coast_q;
  always @*
  begin
    rd_hit  = 1'b1;
    case (s_axi_araddr[9:2])
      `IDX_RED_OFFSET_LOW:     rd_byte = red_offset_low_q;
      `IDX_GREEN_OFFSET_HIGH:  rd_byte = green_offset_high_q;
      `IDX_GREEN_OFFSET_LOW:   rd_byte = green_offset_low_q;
      `IDX_BLUE_OFFSET_HIGH:   rd_byte = blue_offset_high_q;
      `IDX_BLUE_OFFSET_LOW:    rd_byte = blue_offset_low_q;
      `IDX_LINE_LENGTH_HIGH:   rd_byte = line_length_high_q;
      `IDX_LINE_LENGTH_LOW:    rd_byte = line_length_low_q;
      `IDX_SAMPLE_PHASE:       rd_byte = sample_phase_q;
      `IDX_COAST_BEFORE_VSYNC: rd_byte = coast_before_vsync_q;
      `IDX_COAST_AFTER_VSYNC:  rd_byte = coast_after_vsync_q;
      `IDX_PLL_OPTIONS:        rd_byte = pll_options_q;
      `IDX_CLAMP_START_HIGH:   rd_byte = clamp_start_high_q;
      `IDX_CLAMP_START_LOW:    rd_byte = clamp_start_low_q;
      `IDX_CLAMP_WIDTH:        rd_byte = clamp_width_q;
      `IDX_FRONT_END_CONFIG:   rd_byte = front_end_config_q;
      `IDX_LOOP_STATUS:        rd_byte = {5'h00, clamp_active, pll_coast, coast_q};
      default:
      begin
        rd_byte = 8'h00;
        rd_hit  = 1'b0;
      end
    endcase
    if (s_axi_araddr[31:10] != 22'h0)
    begin
      rd_byte = 8'h00;
      rd_hit  = 1'b0;
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h0, rd_byte};
        s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // oversampling ratio 1,2,4,8 as a left shift
  wire [1:0]  os_shift = front_end_config_q[`CFG_OVERSAMPLE_MSB:`CFG_OVERSAMPLE_LSB];
  wire        loop_on  = front_end_config_q[`CFG_LOOP_ENABLE];
  wire [13:0] len_raw  = {line_length_high_q[5:0], wbyte};
  wire [LINE_W-1:0] start_scaled = {{(LINE_W-14){1'b0}},
    clamp_start_high_q[5:0], clamp_start_low_q} << os_shift; // [RULE17]
  wire [LINE_W-1:0] width_scaled = {{(LINE_W-8){1'b0}}, clamp_width_q} << os_shift; // [RULE17]

  // sync edge detect; inputs are synchronous
  reg        hsync_q, vsync_q;
  wire       hs_lead  = hsync_in && !hsync_q;
  wire       hs_trail = !hsync_in && hsync_q;
  wire       vs_start = vsync_in && !vsync_q;
  wire       vs_end   = !vsync_in && vsync_q;
  reg [7:0]  line_cnt_q, post_cnt_q;
  reg [7:0]  lines_per_frame_q;
  reg        post_q;

  // internal coast: count lines per frame, open pre lines ahead of vsync
  // the frame length is learned from the previous frame, so the first frame has no pre-coast
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hsync_q           <= 1'b0;
      vsync_q           <= 1'b0;
      line_cnt_q        <= 8'h00;
      lines_per_frame_q <= 8'h00;
      post_cnt_q        <= 8'h00;
      post_q            <= 1'b0;
      coast_q           <= 1'b0;
    end
    else
    begin
      hsync_q <= hsync_in;
      vsync_q <= vsync_in;
      if (vs_start)
      begin
        lines_per_frame_q <= line_cnt_q;
        line_cnt_q        <= 8'h00;
      end
      else if (hs_lead && line_cnt_q != 8'hFF)
        line_cnt_q <= line_cnt_q + 8'h01;
      if (vs_end)
      begin
        post_q     <= (coast_after_vsync_q != 8'h00); // [RULE7]
        post_cnt_q <= coast_after_vsync_q;
      end
      else if (post_q && hs_lead)
      begin
        post_cnt_q <= post_cnt_q - 8'h01;
        post_q     <= (post_cnt_q != 8'h01); // [RULE7]
      end
      coast_q <= vsync_in || vsync_q || post_q ||
                 (lines_per_frame_q > coast_before_vsync_q &&
                  line_cnt_q > lines_per_frame_q - coast_before_vsync_q); // [RULE6]
    end
  end

  // coast source and external polarity
  wire ext_coast = coast_in ^ pll_options_q[`OPT_COAST_ACTIVE_LOW]; // [RULE11]
  wire coast_now = pll_options_q[`OPT_COAST_EXTERNAL] ? ext_coast : coast_q; // [RULE10]
  wire lock_edge = pll_options_q[`OPT_LOCK_LEADING] ? hs_lead : hs_trail; // [RULE8]

  // clamp pixel counter from raw hsync trailing edge
  reg [LINE_W-1:0] pix_q;
  always @(posedge aclk)
  begin
    if (!aresetn)
      pix_q <= {LINE_W{1'b0}};
    else if (hs_trail)
      pix_q <= {LINE_W{1'b0}};
    else if (pix_q != {LINE_W{1'b1}})
      pix_q <= pix_q + {{(LINE_W-1){1'b0}}, 1'b1};
  end

  // clamp window; dc-coupled or zero width never connects the dac
  wire clamp_d = !front_end_config_q[`CFG_DC_COUPLED] && (clamp_width_q != 8'h00) &&
                 !hs_trail && (pix_q + 1'b1 >= start_scaled) && // [RULE14] [RULE15]
                 (pix_q + 1'b1 < start_scaled + width_scaled); // [RULE13] [RULE19]

  // offsets: dac path when loop off, signed digital word around mid code when on
  wire [9:0] g_word = {green_offset_high_q, green_offset_low_q[7:6]};
  wire [9:0] b_word = {blue_offset_high_q, blue_offset_low_q[7:6]};

  // registered outputs
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      green_offset_dac             <= 10'h000;
      blue_offset_dac              <= 10'h000;
      green_digital_offset         <= 10'h000;
      blue_digital_offset          <= 10'h000;
      pll_line_length              <= {{(LINE_W-16){1'b0}},
                                       `RST_LINE_LENGTH_HIGH, `RST_LINE_LENGTH_LOW};
      pll_line_load                <= 1'b0;
      pll_phase_step               <= 6'h00;
      pll_coast                    <= 1'b0;
      pll_lock_pulse               <= 1'b0;
      pll_clock_invert             <= 1'b0;
      use_external_pixel_clock_pin <= 1'b0;
      clamp_active                 <= 1'b0;
    end
    else
    begin
      green_offset_dac     <= loop_on ? 10'h200 : g_word; // [RULE2]
      blue_offset_dac      <= loop_on ? 10'h200 : b_word; // [RULE2]
      green_digital_offset <= loop_on ? (g_word ^ 10'h200) : 10'h000; // [RULE16]
      blue_digital_offset  <= loop_on ? (b_word ^ 10'h200) : 10'h000; // [RULE16]
      pll_line_load        <= 1'b0;
      if (do_write && wr_low && wr_idx[7:0] == `IDX_LINE_LENGTH_LOW)
      begin
        pll_line_length <= {{(LINE_W-14){1'b0}}, len_raw} << os_shift; // [RULE4] [RULE17]
        pll_line_load   <= 1'b1; // [RULE4]
      end
      pll_phase_step               <= sample_phase_q[5:0]; // [RULE5]
      pll_coast                    <= coast_now; // [RULE18]
      pll_lock_pulse               <= lock_edge && !coast_now; // [RULE8] [RULE18]
      pll_clock_invert <= pll_options_q[`OPT_CLOCK_INVERT_PIN_ENABLE] && clock_invert_pin; // [RULE9]
      use_external_pixel_clock_pin <= pll_options_q[`OPT_EXT_PIXEL_CLOCK]; // [RULE12]
      clamp_active                 <= clamp_d;
    end
  end

endmodule // pll_coast_clamp_control

`default_nettype wire

// file: core/pll_coast_clamp_regs.vh
// register map, field positions and reset values for the pll coast clamp control
`ifndef PLL_COAST_CLAMP_REGS_VH
`define PLL_COAST_CLAMP_REGS_VH
// printed offsets are not all multiples of four: these are indexes, byte address = 4*index
`define IDX_RED_OFFSET_LOW     8'h19
`define IDX_GREEN_OFFSET_HIGH  8'h1A
`define IDX_GREEN_OFFSET_LOW   8'h1B
`define IDX_BLUE_OFFSET_HIGH   8'h1C
`define IDX_BLUE_OFFSET_LOW    8'h1D
`define IDX_LINE_LENGTH_HIGH   8'h1E
`define IDX_LINE_LENGTH_LOW    8'h1F
`define IDX_SAMPLE_PHASE       8'h20
`define IDX_COAST_BEFORE_VSYNC 8'h21
`define IDX_COAST_AFTER_VSYNC  8'h22
`define IDX_PLL_OPTIONS        8'h23
`define IDX_CLAMP_START_HIGH   8'h24
`define IDX_CLAMP_START_LOW    8'h25
`define IDX_CLAMP_WIDTH        8'h26
`define IDX_FRONT_END_CONFIG   8'h27
`define IDX_LOOP_STATUS        8'h28
// reset values
`define RST_OFFSET_HIGH        8'h80
`define RST_OFFSET_LOW         8'h00
`define RST_LINE_LENGTH_HIGH   8'h06
`define RST_LINE_LENGTH_LOW    8'h98
`define RST_SAMPLE_PHASE       8'h00
`define RST_COAST_LINES        8'h04
`define RST_PLL_OPTIONS        8'h00
`define RST_CLAMP_START_HIGH   8'h00
`define RST_CLAMP_START_LOW    8'h02
`define RST_CLAMP_WIDTH        8'h10
`define RST_FRONT_END_CONFIG   8'h00
// pll_options bits
`define OPT_LOCK_LEADING       0
`define OPT_CLOCK_INVERT_PIN_ENABLE      1
`define OPT_COAST_EXTERNAL     2
`define OPT_COAST_ACTIVE_LOW   3
`define OPT_EXT_PIXEL_CLOCK    4
// front_end_config bits
`define CFG_LOOP_ENABLE        0
`define CFG_DC_COUPLED         1
`define CFG_OVERSAMPLE_LSB     2
`define CFG_OVERSAMPLE_MSB     3
// axi responses
`define RESP_OKAY              2'h0
`define RESP_SLVERR            2'h2
`endif

// file: test/sync_source.sv
// free-running sync source standing in for the video timing at the far side
`timescale 1ns/1ns
`default_nettype none
module sync_source #(
  parameter int LINE     = 64,
  parameter int HS_W     = 8,
  parameter int LINES    = 20,
  parameter int VS_LINES = 2
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  output wire logic hsync_in,
  output wire logic vsync_in
);
  int pix = 0;
  int ln  = 0;
  // pixel and line counters; held at zero while reset is low, otherwise the syncs never stop
  always @(posedge aclk)
  begin
    if (!aresetn || pix == LINE - 1)
    begin
      pix <= 0;
      ln  <= (!aresetn || ln == LINES - 1) ? 0 : ln + 1;
    end
    else
      pix <= pix + 1;
  end
  // vsync edges land on hsync leading edges, so line counts stay exact
  assign hsync_in = pix < HS_W;
  assign vsync_in = ln >= LINES - VS_LINES;
endmodule // sync_source
`default_nettype wire

// file: test/pll_coast_clamp_control_sva.sv
// port assertions for the pll coast clamp control
`timescale 1ns/1ns
`default_nettype none
module pcc_sva #(
  parameter LINE_W = 17
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              clock_invert_pin,
  input wire logic [LINE_W-1:0] pll_line_length,
  input wire logic              pll_line_load,
  input wire logic [5:0]        pll_phase_step,
  input wire logic              pll_coast,
  input wire logic              pll_lock_pulse,
  input wire logic              pll_clock_invert,
  input wire logic              use_external_pixel_clock_pin,
  input wire logic              clamp_active
);
  logic        bv_q;      // outputs may trail the write answer by one cycle
  logic [11:0] clamp_n_q; // longest legal clamp is 255 pixels at 8x
  // helper state for the timing checks
  always @(posedge aclk)
  begin
    bv_q      <= aresetn & s_axi_bvalid;
    clamp_n_q <= (aresetn && clamp_active) ? clamp_n_q + 12'h001 : 12'h000;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_len_on_load; $changed(pll_line_length) |-> pll_line_load; endproperty
  a_len_on_load: assert property (p_len_on_load) else $error("length moved, no load");
  property p_load_pulse; pll_line_load |=> !pll_line_load; endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("load pulse too long");
  property p_clk_inv; pll_clock_invert |-> $past(clock_invert_pin); endproperty
  a_clk_inv: assert property (p_clk_inv) else $error("invert without pin");
  property p_coast_hold; pll_coast && $past(pll_coast) |-> !pll_lock_pulse; endproperty
  a_coast_hold: assert property (p_coast_hold) else $error("lock during coast");
  property p_lock_once; pll_lock_pulse |=> !pll_lock_pulse; endproperty
  a_lock_once: assert property (p_lock_once) else $error("lock pulse too long");
  property p_clamp_len; clamp_active |-> clamp_n_q < 12'h7F8; endproperty
  a_clamp_len: assert property (p_clamp_len) else $error("clamp too long");
  property p_opt_write;
    $changed({use_external_pixel_clock_pin, pll_phase_step}) |-> s_axi_bvalid || bv_q;
  endproperty
  a_opt_write: assert property (p_opt_write) else $error("option moved alone");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  c_load: cover property (pll_line_load);
  c_coast: cover property ($rose(pll_coast));
  c_clamp: cover property ($fell(clamp_active));
endmodule // pcc_sva
bind pll_coast_clamp_control pcc_sva #(.LINE_W(LINE_W)) u_sva (.aclk, .aresetn,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .clock_invert_pin, .pll_line_length,
  .pll_line_load, .pll_phase_step, .pll_coast, .pll_lock_pulse, .pll_clock_invert,
  .use_external_pixel_clock_pin, .clamp_active);
`default_nettype wire

// file: test/tb_top.sv
// self-checking bench for the pll coast clamp control
`include "pll_coast_clamp_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int LINE = 64;
  localparam int HS_W = 8;
  localparam int LINES = 20;
  logic        aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, pin;
  logic        coast_in = 1'h0, clock_invert_pin = 1'h0, rnd_pins = 1'h0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        hsync_in, vsync_in, pll_line_load, pll_coast, pll_lock_pulse;
  logic        pll_clock_invert, use_external_pixel_clock_pin, clamp_active;
  logic [9:0]  green_offset_dac, blue_offset_dac, green_digital_offset, blue_digital_offset;
  logic [16:0] pll_line_length;
  logic [5:0]  pll_phase_step;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rdat;
  logic [7:0]  d, lo, wv [0:13];
  logic [7:0]  rst [0:13] = '{8'h00, 8'h80, 8'h00, 8'h80, 8'h00, 8'h06, 8'h98,
                             8'h00, 8'h04, 8'h04, 8'h00, 8'h00, 8'h02, 8'h10};
  int          seed = 32'h1F451EAE, fails = 0, checks = 0, cyc = 0;
  int          p0, p, w, nc, nl, bad;
  pll_coast_clamp_control dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hsync_in, .vsync_in,
    .coast_in, .clock_invert_pin, .green_offset_dac, .blue_offset_dac, .green_digital_offset,
    .blue_digital_offset, .pll_line_length, .pll_line_load, .pll_phase_step, .pll_coast,
    .pll_lock_pulse, .pll_clock_invert, .use_external_pixel_clock_pin, .clamp_active);
  sync_source #(.LINE(LINE), .HS_W(HS_W), .LINES(LINES)) u_src (.aclk, .aresetn,
    .hsync_in, .vsync_in);
  always #4 aclk = ~aclk;
  // random pin activity, and a cycle ceiling so a hang still reaches the verdict
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (rnd_pins)
    begin
      coast_in         <= $random(seed);
      clock_invert_pin <= $random(seed);
    end
    if (cyc == 20000)
    begin
      fails = fails + 1;
      finish_test;
    end
  end
  task automatic finish_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %0s expected %h seen %h", nm, e, g);
    end
  endtask
  // unused bits read back as zero
  function automatic logic [7:0] msk(input logic [7:0] i);
    case (i)
      `IDX_RED_OFFSET_LOW, `IDX_GREEN_OFFSET_LOW, `IDX_BLUE_OFFSET_LOW: msk = 8'hC0;
      `IDX_LINE_LENGTH_HIGH, `IDX_SAMPLE_PHASE, `IDX_CLAMP_START_HIGH: msk = 8'h3F;
      `IDX_PLL_OPTIONS: msk = 8'h1F;
      default: msk = 8'hFF;
    endcase
  endfunction
  // address and data offered together, each released once taken
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    s_axi_awaddr  <= {22'h0, i, 2'h0};
    s_axi_wdata   <= {24'h0, v};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bready <= 1'h0;
        rsp = s_axi_bresp;
      end
    end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
  endtask
  task automatic rd(input logic [7:0] i);
    s_axi_araddr  <= {22'h0, i, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rready <= 1'h0;
        rdat = s_axi_rdata;
        rsp  = s_axi_rresp;
      end
    end while (s_axi_arvalid || s_axi_rready);
  endtask
  // one frame: coast cycles, lock pulses, pulses far from the chosen edge
  task automatic frame(input logic lead);
    nc = 0;
    nl = 0;
    bad = 0;
    repeat (LINES * LINE)
    begin
      @(posedge aclk);
      nc += pll_coast;
      p = u_src.pix - (lead ? 0 : HS_W);
      nl += pll_lock_pulse;
      bad += pll_lock_pulse && (p < 1 || p > 4);
    end
  endtask
  // start position and length of the next whole clamp pulse
  task automatic clamp_meas;
    w = 0;
    while (clamp_active) @(posedge aclk);
    do @(posedge aclk); while (!clamp_active);
    p = u_src.pix;
    while (clamp_active)
    begin
      w++;
      @(posedge aclk);
    end
  endtask
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    for (int i = 0; i < 14; i++)
    begin
      rd(8'h19 + i[7:0]);
      chk("reset value", rst[i], rdat);
    end
    rd(8'h18);
    chk("unmapped read", {30'h0, `RESP_SLVERR}, {rdat[29:0], rsp});
    wr(`IDX_LOOP_STATUS, 8'hFF);
    chk("read-only write", `RESP_SLVERR, rsp);
    chk("reset length", 32'h698, pll_line_length);
    $display("test defaults done");
    for (int i = 0; i < 14; i++)
    begin
      d = $random(seed);
      wr(8'h19 + i[7:0], d);
      rd(8'h19 + i[7:0]);
      wv[i] = d & msk(8'h19 + i[7:0]);
      chk("readback", wv[i], rdat);
    end
    chk("length", {wv[5][5:0], wv[6]}, pll_line_length);
    chk("phase", wv[7][5:0], pll_phase_step);
    chk("pixel clock source", wv[10][4], use_external_pixel_clock_pin);
    wr(`IDX_LINE_LENGTH_HIGH, 8'h15);
    chk("length held", {wv[5][5:0], wv[6]}, pll_line_length);
    wr(`IDX_LINE_LENGTH_LOW, 8'hAB);
    chk("length loaded", 32'h15AB, pll_line_length);
    wr(`IDX_FRONT_END_CONFIG, 8'h0C);
    wr(`IDX_LINE_LENGTH_HIGH, 8'hFF);
    wr(`IDX_LINE_LENGTH_LOW, 8'hFF);
    chk("oversampled length", 32'h1FFF8, pll_line_length);
    $display("test registers done");
    for (int c = 0; c < 4; c++)
    begin
      d  = (c == 3) ? 8'hFF : $random(seed);
      lo = (c == 3) ? 8'hC0 : $random(seed);
      wr(c[0] ? `IDX_BLUE_OFFSET_HIGH : `IDX_GREEN_OFFSET_HIGH, d);
      wr(c[0] ? `IDX_BLUE_OFFSET_LOW : `IDX_GREEN_OFFSET_LOW, lo);
      wr(`IDX_FRONT_END_CONFIG, {7'h0, c[1]});
      chk("offset dac", c[1] ? 10'h200 : {d, lo[7:6]},
          c[0] ? blue_offset_dac : green_offset_dac);
      chk("digital offset", c[1] ? {~d[7], d[6:0], lo[7:6]} : 10'h0,
          c[0] ? blue_digital_offset : green_digital_offset);
    end
    wr(`IDX_FRONT_END_CONFIG, 8'h00);
    $display("test offsets done");
    for (int k = 0; k < 4; k++)
    begin
      wr(`IDX_PLL_OPTIONS, {4'h0, k[1], 3'h4});
      coast_in <= k[0];
      repeat (4) @(posedge aclk);
      chk("external coast", k[0] ^ k[1], pll_coast);
      rd(`IDX_LOOP_STATUS);
      chk("status coast", k[0] ^ k[1], rdat[1]);
    end
    rnd_pins <= 1'h1;
    wr(`IDX_COAST_BEFORE_VSYNC, 8'h02);
    wr(`IDX_COAST_AFTER_VSYNC, 8'h03);
    for (int k = 0; k < 2; k++)
    begin
      wr(`IDX_PLL_OPTIONS, {7'h0, k[0]});
      repeat (2 * LINES * LINE) @(posedge aclk);
      frame(k[0]);
      chk("coast lines", 7, (nc + LINE / 2) / LINE);
      chk("lock placement", 0, bad);
      if (!k[0]) chk("lock count", LINES - 7, nl);
    end
    for (int k = 0; k < 2; k++)
    begin
      wr(`IDX_PLL_OPTIONS, {6'h0, k[0], 1'h0});
      repeat (16)
      begin
        pin = clock_invert_pin;
        @(posedge aclk);
        chk("clock invert", k[0] & pin, pll_clock_invert);
      end
    end
    $display("test pll done");
    wr(`IDX_CLAMP_START_HIGH, 8'h00);
    wr(`IDX_CLAMP_WIDTH, 8'h07);
    for (int k = 0; k < 3; k++)
    begin
      wr(`IDX_FRONT_END_CONFIG, k == 2 ? 8'h04 : 8'h00);
      wr(`IDX_CLAMP_START_LOW, k == 1 ? 8'h09 : 8'h05);
      clamp_meas;
      if (k == 0) p0 = p;
      chk("clamp width", k == 2 ? 14 : 7, w);
      chk("clamp start", k == 0 ? 0 : (k == 1 ? 4 : 5), p - p0);
    end
    for (int k = 0; k < 2; k++)
    begin
      wr(`IDX_FRONT_END_CONFIG, {6'h0, k[0], 1'h0});
      wr(`IDX_CLAMP_WIDTH, k[0] ? 8'h07 : 8'h00);
      repeat (LINE) @(posedge aclk);
      w = 0;
      repeat (2 * LINE) @(posedge aclk) w += clamp_active;
      chk("clamp idle", 0, w);
    end
    $display("test clamp done");
    finish_test;
  end
endmodule // tb_top
`default_nettype wire
